// >>> shared/e1_alarm_pkg.sv
// constants and carrier types for the E1 alarm and monitor interrupt block
//
// Overview of operation
// (R1) all-ones alarm change flag sets on any status edge; write one clears it
// (R2) remote alarm change flag sets on any status edge; write one clears it
// (R3) carrier-fail change flag sets on any status edge; write one clears it
// (R4) select 0: under 3 zeros per 512-bit window, out of sync, declares all-ones
// (R5) select 1: two consecutive windows must agree to declare or clear all-ones
// (R6) remote select 0: declare after 4 ones in a row, clear on a zero
// (R7) remote select 1: declare on a single one, clear on a single zero
// (R8) rising edge of manual latch bit snapshots all monitor counters at once
// (R9) periodic latch bit set: snapshot every one second, otherwise never automatically
// (R10) bit 7 flags pattern checker counter overflow; write one clears
// (R11) bit 6 flags transmit far-end block error overflow; write one clears
// (R12) bit 5 flags receive far-end block error overflow; write one clears
// (R13) bit 4 flags data-link error counter overflow; write one clears
// (R14) bit 3 flags alignment change counter overflow; write one clears
// (R15) bit 2 flags frame loss counter overflow; write one clears
// (R16) bit 1 flags framing bit error overflow; write one clears
// (R17) bit 0 of first flag register: checksum error overflow; write one clears
// (R18) bit 0 of second flag register: line code violation overflow; write one clears
// (R19) first enable register gates each overflow flag onto the interrupt bit-for-bit
// (R20) second enable register bit 0 gates line code overflow; other bits reserved
// (R21) carrier-fail asserts after 100 ms out of sync, clears after 100 ms in sync
// (R22) alarm enable register gates each alarm change flag onto the interrupt
// (R23) active-low interrupt is OR of enabled set flags, held until all cleared
package e1_alarm_pkg;

    // register indices; the APB byte address is four times the index
    localparam logic [7:0] IDX_ALARM_STATUS   = 8'hB9;
    localparam logic [7:0] IDX_ALARM_ENABLE   = 8'hBA;
    localparam logic [7:0] IDX_ALARM_FLAGS    = 8'hBB;
    localparam logic [7:0] IDX_CRITERIA_SEL   = 8'hBC;
    localparam logic [7:0] IDX_UPDATE_CTRL    = 8'hC2;
    localparam logic [7:0] IDX_OVF_ENABLE_0   = 8'hC3;
    localparam logic [7:0] IDX_OVF_ENABLE_1   = 8'hC4;
    localparam logic [7:0] IDX_OVF_FLAGS_0    = 8'hC5;
    localparam logic [7:0] IDX_OVF_FLAGS_1    = 8'hC6;

    // field positions
    localparam int REMOTE_SEL_BIT    = 0;
    localparam int ALL_ONES_SEL_BIT  = 1;
    localparam int PERIODIC_BIT      = 0;
    localparam int MANUAL_BIT        = 1;

    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;

    // detection figures
    localparam int unsigned WINDOW_BITS        = 512;
    localparam logic [1:0]  ZERO_LIMIT         = 2'h3;
    localparam logic [2:0]  REMOTE_ONES_NEEDED = 3'h4;

    // timing
    localparam longint unsigned CLOCK_HZ          = 100_000_000;
    localparam longint unsigned RED_PERSIST_MS    = 100;
    localparam longint unsigned AUTO_LATCH_S      = 1;
    localparam int unsigned RED_PERSIST_CYCLES =
        int'(CLOCK_HZ * RED_PERSIST_MS / 1000);
    localparam int unsigned AUTO_LATCH_CYCLES =
        int'(CLOCK_HZ * AUTO_LATCH_S);

    // alarm triple in register bit order b2..b0
    typedef struct packed {
        logic allOnes;
        logic remote;
        logic carrierFail;
    } alarm_bits_t;

    // overflow events: line code in bit 8, first flag register below it
    typedef struct packed {
        logic       lineCode;
        logic [7:0] group0;
    } overflow_bits_t;

endpackage

// >>> src/e1_alarm_performance_monitor_irq.sv
// E1 alarm change flags, alarm criteria, monitor latch and overflow interrupt logic
module e1_alarm_performance_monitor_irq #(
    parameter int unsigned RED_CYCLES   = e1_alarm_pkg::RED_PERSIST_CYCLES,
    parameter int unsigned LATCH_CYCLES = e1_alarm_pkg::AUTO_LATCH_CYCLES,
    parameter int unsigned ADDR_W       = 12
) (
    // clock and reset
    input  wire logic                         clock,
    input  wire logic                         rst,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [ADDR_W-1:0]            paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // receive framer inputs
    input  wire logic                         rxBitValid,
    input  wire logic                         rxBit,
    input  wire logic                         basicFrameSync,
    input  wire logic                         aBitValid,
    input  wire logic                         aBit,
    // performance monitor counters
    input  wire e1_alarm_pkg::overflow_bits_t overflowEvent,
    output logic                              counterLatch,
    // alarms and interrupt
    output e1_alarm_pkg::alarm_bits_t         alarms,
    output logic                              intN
);

    localparam int RED_W   = $clog2(RED_CYCLES + 1);
    localparam int LATCH_W = $clog2(LATCH_CYCLES + 1);
    localparam int WIN_W   = $clog2(e1_alarm_pkg::WINDOW_BITS);
    localparam logic [RED_W-1:0]   RED_LAST   = RED_W'(RED_CYCLES - 1);
    localparam logic [LATCH_W-1:0] LATCH_LAST = LATCH_W'(LATCH_CYCLES - 1);
    localparam logic [WIN_W-1:0]   WIN_LAST   = WIN_W'(e1_alarm_pkg::WINDOW_BITS - 1);

    // register index from a byte address; low two bits and bits above the index must be zero
    function automatic logic [8:0] regIndex(input logic [ADDR_W-1:0] addr);
        regIndex = {(addr[1:0] != 2'h0) || (addr[ADDR_W-1:10] != '0), addr[9:2]};
    endfunction

    function automatic logic isMapped(input logic [8:0] idx);
        case (idx)
            {1'b0, e1_alarm_pkg::IDX_ALARM_STATUS},
            {1'b0, e1_alarm_pkg::IDX_ALARM_ENABLE},
            {1'b0, e1_alarm_pkg::IDX_ALARM_FLAGS},
            {1'b0, e1_alarm_pkg::IDX_CRITERIA_SEL},
            {1'b0, e1_alarm_pkg::IDX_UPDATE_CTRL},
            {1'b0, e1_alarm_pkg::IDX_OVF_ENABLE_0},
            {1'b0, e1_alarm_pkg::IDX_OVF_ENABLE_1},
            {1'b0, e1_alarm_pkg::IDX_OVF_FLAGS_0},
            {1'b0, e1_alarm_pkg::IDX_OVF_FLAGS_1}: isMapped = 1'b1;
            default:                                isMapped = 1'b0;
        endcase
    endfunction

    // software state
    e1_alarm_pkg::alarm_bits_t    alarmEnable;
    e1_alarm_pkg::alarm_bits_t    alarmFlags;
    e1_alarm_pkg::alarm_bits_t    alarmSeen;
    e1_alarm_pkg::overflow_bits_t ovfEnable;
    e1_alarm_pkg::overflow_bits_t ovfFlags;
    logic                         allOnesSel;
    logic                         remoteSel;
    logic                         manualLatch;
    logic                         periodicLatch;
    logic                         manualSeen;

    // detector state
    logic [WIN_W-1:0]             windowPos;
    logic [1:0]                   zeroCount;
    logic                         prevWindowLow;
    logic [2:0]                   onesRun;
    logic [RED_W-1:0]             redCount;
    logic [LATCH_W-1:0]           latchTimer;

    logic [8:0]                   accIndex;
    logic                         writeHit;
    logic                         mapped;
    logic [1:0]                   zerosNow;
    logic                         windowLow;
    logic                         windowEnd;
    logic [2:0]                   next_onesRun;
    logic                         irqPending;

    // ---------------- apb slave ----------------
    assign accIndex = regIndex(paddr);
    assign mapped   = isMapped(accIndex);
    assign writeHit = psel & penable & pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;

    function automatic logic wrTo(input logic [8:0] idx, input logic [7:0] target);
        wrTo = (idx == {1'b0, target});
    endfunction

    // read data is captured in the setup cycle, so it stands through the access phase
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            case (accIndex)
                {1'b0, e1_alarm_pkg::IDX_ALARM_STATUS}: prdata <= {29'h0, alarms};
                {1'b0, e1_alarm_pkg::IDX_ALARM_ENABLE}: prdata <= {29'h0, alarmEnable};
                {1'b0, e1_alarm_pkg::IDX_ALARM_FLAGS}:  prdata <= {29'h0, alarmFlags};
                {1'b0, e1_alarm_pkg::IDX_CRITERIA_SEL}:
                    prdata <= {30'h0, allOnesSel, remoteSel};
                {1'b0, e1_alarm_pkg::IDX_UPDATE_CTRL}:
                    prdata <= {30'h0, manualLatch, periodicLatch};
                {1'b0, e1_alarm_pkg::IDX_OVF_ENABLE_0}: prdata <= {24'h0, ovfEnable.group0};
                {1'b0, e1_alarm_pkg::IDX_OVF_ENABLE_1}: prdata <= {31'h0, ovfEnable.lineCode};
                {1'b0, e1_alarm_pkg::IDX_OVF_FLAGS_0}:  prdata <= {24'h0, ovfFlags.group0};
                {1'b0, e1_alarm_pkg::IDX_OVF_FLAGS_1}:  prdata <= {31'h0, ovfFlags.lineCode};
                default:                                 prdata <= 32'h0000_0000;
            endcase
        end
    end

    // control registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            alarmEnable   <= '0;
            ovfEnable     <= '0;
            allOnesSel    <= 1'b0;
            remoteSel     <= 1'b0;
            manualLatch   <= 1'b0;
            periodicLatch <= 1'b0;
        end else if (writeHit) begin
            if (wrTo(accIndex, e1_alarm_pkg::IDX_ALARM_ENABLE)) begin
                alarmEnable <= pwdata[2:0]; // [R22]
            end
            if (wrTo(accIndex, e1_alarm_pkg::IDX_CRITERIA_SEL)) begin
                allOnesSel <= pwdata[e1_alarm_pkg::ALL_ONES_SEL_BIT];
                remoteSel  <= pwdata[e1_alarm_pkg::REMOTE_SEL_BIT];
            end
            if (wrTo(accIndex, e1_alarm_pkg::IDX_UPDATE_CTRL)) begin
                manualLatch   <= pwdata[e1_alarm_pkg::MANUAL_BIT];
                periodicLatch <= pwdata[e1_alarm_pkg::PERIODIC_BIT];
            end
            if (wrTo(accIndex, e1_alarm_pkg::IDX_OVF_ENABLE_0)) begin
                ovfEnable.group0 <= pwdata[7:0]; // [R19]
            end
            if (wrTo(accIndex, e1_alarm_pkg::IDX_OVF_ENABLE_1)) begin
                ovfEnable.lineCode <= pwdata[0]; // [R20]
            end
        end
    end

    // ---------------- all-ones detector ----------------
    assign zerosNow  = (zeroCount == e1_alarm_pkg::ZERO_LIMIT) ? zeroCount
                     : zeroCount + {1'b0, ~rxBit};
    assign windowLow = (zerosNow < e1_alarm_pkg::ZERO_LIMIT);
    assign windowEnd = rxBitValid & (windowPos == WIN_LAST);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            windowPos     <= '0;
            zeroCount     <= 2'h0;
            prevWindowLow <= 1'b0;
        end else if (rxBitValid) begin
            if (windowEnd) begin
                windowPos     <= '0;
                zeroCount     <= 2'h0;
                prevWindowLow <= windowLow;
            end else begin
                windowPos <= windowPos + WIN_W'(1);
                zeroCount <= zerosNow;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            alarms.allOnes <= 1'b0;
        end else if (windowEnd) begin
            if (!allOnesSel) begin
                if (windowLow && !basicFrameSync) begin
                    alarms.allOnes <= 1'b1; // [R4]
                end else if (!windowLow) begin
                    alarms.allOnes <= 1'b0; // [R4]
                end
            end else begin
                if (windowLow && prevWindowLow) begin
                    alarms.allOnes <= 1'b1; // [R5]
                end else if (!windowLow && !prevWindowLow) begin
                    alarms.allOnes <= 1'b0; // [R5]
                end
            end
        end
    end

    // ---------------- remote detector ----------------
    assign next_onesRun = (onesRun == e1_alarm_pkg::REMOTE_ONES_NEEDED) ? onesRun
                        : onesRun + 3'h1;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            onesRun       <= 3'h0;
            alarms.remote <= 1'b0;
        end else if (aBitValid) begin
            if (!aBit) begin
                onesRun       <= 3'h0;
                alarms.remote <= 1'b0; // [R6] [R7]
            end else begin
                onesRun <= next_onesRun;
                if (remoteSel || next_onesRun == e1_alarm_pkg::REMOTE_ONES_NEEDED) begin
                    alarms.remote <= 1'b1; // [R6] [R7]
                end
            end
        end
    end

    // ---------------- carrier-fail persistence ----------------
    // the count runs only while sync disagrees with the alarm; any glitch restarts it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            redCount           <= '0;
            alarms.carrierFail <= 1'b0;
        end else if (basicFrameSync == alarms.carrierFail) begin
            if (redCount == RED_LAST) begin
                redCount           <= '0;
                alarms.carrierFail <= ~alarms.carrierFail; // [R21]
            end else begin
                redCount <= redCount + RED_W'(1);
            end
        end else begin
            redCount <= '0;
        end
    end

    // ---------------- alarm change flags ----------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            alarmSeen <= '0;
        end else begin
            alarmSeen <= alarms;
        end
    end

    // a status edge in the clearing cycle keeps the flag set
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            alarmFlags <= '0;
        end else begin
            alarmFlags <= (alarmFlags
                & ~((writeHit && wrTo(accIndex, e1_alarm_pkg::IDX_ALARM_FLAGS))
                    ? pwdata[2:0] : 3'h0))
                | (alarms ^ alarmSeen); // [R1] [R2] [R3]
        end
    end

    // ---------------- overflow flags ----------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ovfFlags <= '0;
        end else begin
            ovfFlags.group0 <= (ovfFlags.group0
                & ~((writeHit && wrTo(accIndex, e1_alarm_pkg::IDX_OVF_FLAGS_0))
                    ? pwdata[7:0] : 8'h00))
                | overflowEvent.group0; // [R10] [R11] [R12] [R13] [R14] [R15] [R16] [R17]
            ovfFlags.lineCode <= (ovfFlags.lineCode
                & ~(writeHit && wrTo(accIndex, e1_alarm_pkg::IDX_OVF_FLAGS_1) && pwdata[0]))
                | overflowEvent.lineCode; // [R18]
        end
    end

    // ---------------- counter snapshot ----------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            manualSeen <= 1'b0;
            latchTimer <= '0;
        end else begin
            manualSeen <= manualLatch;
            if (!periodicLatch || latchTimer == LATCH_LAST) begin
                latchTimer <= '0;
            end else begin
                latchTimer <= latchTimer + LATCH_W'(1);
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            counterLatch <= 1'b0;
        end else begin
            counterLatch <= (manualLatch & ~manualSeen) // [R8]
                          | (periodicLatch && latchTimer == LATCH_LAST); // [R9]
        end
    end

    // ---------------- interrupt ----------------
    assign irqPending = |(alarmFlags & alarmEnable) // [R22]
                      | |(ovfFlags & ovfEnable); // [R19] [R20]

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            intN <= 1'b1;
        end else begin
            intN <= ~irqPending; // [R23]
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_ones_flag_set: assert property ( // [R1]
        (alarms.allOnes != alarmSeen.allOnes) |=> alarmFlags.allOnes)
        else $error("all-ones change not flagged");

    a_remote_flag_set: assert property ( // [R2]
        (alarms.remote != alarmSeen.remote) |=> alarmFlags.remote)
        else $error("remote change not flagged");

    a_fail_flag_set: assert property ( // [R3]
        $changed(alarms.carrierFail) |-> ##1 alarmFlags.carrierFail)
        else $error("carrier-fail change not flagged");

    a_ones_single_window: assert property ( // [R4]
        windowEnd && !allOnesSel && windowLow && !basicFrameSync |=> alarms.allOnes)
        else $error("all-ones not declared on quiet window");

    a_ones_two_windows: assert property ( // [R5]
        windowEnd && allOnesSel && (windowLow != prevWindowLow)
        |=> $stable(alarms.allOnes))
        else $error("all-ones moved on a single window");

    a_remote_four_ones: assert property ( // [R6]
        !remoteSel && !alarms.remote && aBitValid && aBit && onesRun < 3'h3
        |=> !alarms.remote)
        else $error("remote declared before four ones");

    a_remote_single: assert property ( // [R7]
        aBitValid && (aBit ? remoteSel : 1'b1) |=> alarms.remote == $past(aBit))
        else $error("remote not following single A bit");

    a_manual_snapshot: assert property ( // [R8]
        $rose(manualLatch) |=> counterLatch)
        else $error("manual snapshot missing");

    a_periodic_quiet: assert property ( // [R9]
        !periodicLatch && !manualLatch && !manualSeen |=> !counterLatch)
        else $error("snapshot without request");

    a_overflow_set: assert property ( // [R10] [R18]
        overflowEvent != '0 |=> (ovfFlags & $past(overflowEvent)) == $past(overflowEvent))
        else $error("overflow event not flagged");

    a_ovf_clear: assert property ( // [R10] [R17]
        writeHit && wrTo(accIndex, e1_alarm_pkg::IDX_OVF_FLAGS_0)
        && overflowEvent.group0 == 8'h00
        |=> (ovfFlags.group0 & $past(pwdata[7:0])) == 8'h00)
        else $error("overflow flag not cleared by write");

    a_alarm_clear: assert property ( // [R1] [R2] [R3]
        writeHit && wrTo(accIndex, e1_alarm_pkg::IDX_ALARM_FLAGS)
        && (alarms ^ alarmSeen) == 3'h0
        |=> (alarmFlags & $past(pwdata[2:0])) == 3'h0)
        else $error("alarm change flag not cleared by write");

    a_fail_persist: assert property ( // [R21]
        basicFrameSync != alarms.carrierFail |=> $stable(alarms.carrierFail))
        else $error("carrier-fail changed without persistence");

    a_irq_level: assert property ( // [R23]
        irqPending |=> !intN)
        else $error("interrupt not asserted");

    a_irq_release: assert property ( // [R19] [R20] [R22]
        !irqPending |=> intN)
        else $error("interrupt held with nothing enabled");

endmodule

// >>> tb/e1_alarm_performance_monitor_irq_tb.sv
// self-checking bench for the E1 alarm and monitor interrupt block
module e1_alarm_performance_monitor_irq_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                         clock;
    logic                         rst;
    logic                         psel;
    logic                         penable;
    logic                         pwrite;
    logic [11:0]                  paddr;
    logic [31:0]                  pwdata;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    logic                         rxBitValid;
    logic                         rxBit;
    logic                         basicFrameSync;
    logic                         aBitValid;
    logic                         aBit;
    logic                         counterLatch;
    logic                         intN;
    e1_alarm_pkg::overflow_bits_t overflowEvent;
    e1_alarm_pkg::alarm_bits_t    alarms;
    logic [31:0]                  rd;
    logic                         err;
    logic [7:0]                   regs [9] = '{8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hC2, 8'hC3,
                                               8'hC4, 8'hC5, 8'hC6};
    int                           n_fail = 0;
    int                           samples_checked = 0;
    int                           nLatch = 0;
    int                           k;
    int                           nWait = 0;
    // model state: enables, flags, remote run length, alarm levels
    int aEn = 0, aFl = 0, en0 = 0, en1 = 0, f0 = 0, f1 = 0;
    int ones = 0, remSt = 0, aoSt = 0, prevFew = 0;

    e1_alarm_performance_monitor_irq #(.RED_CYCLES(20), .LATCH_CYCLES(50), .ADDR_W(12)) dut (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxBitValid(rxBitValid), .rxBit(rxBit),
        .basicFrameSync(basicFrameSync), .aBitValid(aBitValid), .aBit(aBit),
        .overflowEvent(overflowEvent), .counterLatch(counterLatch), .alarms(alarms),
        .intN(intN)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        if (counterLatch === 1'b1) begin
            nLatch <= nLatch + 1;
        end
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer: setup, access held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        nWait = 0;
        while (pready !== 1'b1) begin
            nWait++;
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input int d);
        apb(1'b1, {2'h0, idx, 2'h0}, 8'(d));
        case (idx)
            8'hBA: aEn = d & 7;
            8'hBB: aFl = aFl & ~d;
            8'hC3: en0 = d & 255;
            8'hC4: en1 = d & 1;
            8'hC5: f0 = f0 & ~d;
            8'hC6: f1 = f1 & ~(d & 1);
            default: ;
        endcase
    endtask

    task automatic rdchk(input logic [7:0] idx, input int exp);
        apb(1'b0, {2'h0, idx, 2'h0}, 8'h00);
        chk(rd, 32'(exp));
        chk({31'h0, err}, 32'h0);
        chk(32'(nWait), 32'h0);
    endtask

    task automatic intchk();
        logic want;
        want = !(((aEn & aFl) != 0) || ((en0 & f0) != 0) || ((en1 & f1) != 0));
        repeat (3) @(posedge clock);
        chk({31'h0, intN}, {31'h0, want});
    endtask

    task automatic abit(input int v, input int sel);
        int nxt;
        @(posedge clock);
        aBitValid <= 1'b1;
        aBit <= v[0];
        @(posedge clock);
        aBitValid <= 1'b0;
        ones = (v != 0) ? ones + 1 : 0;
        nxt = (v != 0) ? ((sel != 0 || ones >= 4) ? 1 : remSt) : 0;
        if (nxt != remSt) aFl |= 2;
        remSt = nxt;
        repeat (2) @(posedge clock);
        chk({31'h0, alarms.remote}, 32'(remSt));
    endtask

    // one aligned 512-bit window with the given number of zeros up front
    task automatic window(input int zeros, input int sel);
        int few;
        int nxt;
        for (int i = 0; i < 512; i++) begin
            @(posedge clock);
            rxBitValid <= 1'b1;
            rxBit <= (i < zeros) ? 1'b0 : 1'b1;
        end
        @(posedge clock);
        rxBitValid <= 1'b0;
        few = (zeros < 3) ? 1 : 0;
        nxt = aoSt;
        if (sel == 0 && few == 1 && basicFrameSync == 1'b0) nxt = 1;
        if (sel == 0 && few == 0) nxt = 0;
        if (sel == 1 && few == 1 && prevFew == 1) nxt = 1;
        if (sel == 1 && few == 0 && prevFew == 0) nxt = 0;
        if (nxt != aoSt) aFl |= 4;
        aoSt = nxt;
        prevFew = few;
        repeat (2) @(posedge clock);
        chk({31'h0, alarms.allOnes}, 32'(aoSt));
    endtask

    task automatic ovf(input int i);
        @(posedge clock);
        overflowEvent <= e1_alarm_pkg::overflow_bits_t'(9'h001 << i);
        @(posedge clock);
        overflowEvent <= '0;
        if (i == 8) f1 = 1;
        else f0 |= 1 << i;
    endtask

    task automatic carrier(input logic sync, input int after);
        basicFrameSync <= sync;
        repeat (10) @(posedge clock);
        chk({31'h0, alarms.carrierFail}, 32'(1 - after));
        repeat (15) @(posedge clock);
        chk({31'h0, alarms.carrierFail}, 32'(after));
        aFl |= 1;
        rdchk(8'hBB, aFl);
    endtask

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        rxBitValid = 1'b0;
        rxBit = 1'b1;
        basicFrameSync = 1'b1;
        aBitValid = 1'b0;
        aBit = 1'b0;
        overflowEvent = '0;
        k = $urandom(32'h3A74);
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        foreach (regs[j]) rdchk(regs[j], 0);
        apb(1'b0, {2'h0, 8'hC3, 2'h1}, 8'h00);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, {2'h1, 8'hC3, 2'h0}, 8'h00);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, {2'h0, 8'hB9, 2'h0}, 8'hFF);
        rdchk(8'hB9, 0);
        wr(8'hC4, 255);
        rdchk(8'hC4, 1);
        wr(8'hBC, 255);
        rdchk(8'hBC, 3);
        wr(8'hBC, 0);
        wr(8'hC3, $urandom & 255);
        wr(8'hC4, $urandom & 1);
        for (int i = 0; i < 9; i++) begin
            ovf(i);
            rdchk(8'hC5, f0);
            rdchk(8'hC6, f1);
            intchk();
        end
        wr(8'hC3, 255);
        intchk();
        wr(8'hC5, $urandom & 255);
        rdchk(8'hC5, f0);
        wr(8'hC5, 255);
        wr(8'hC6, 1);
        rdchk(8'hC6, f1);
        intchk();
        wr(8'hBA, $urandom & 7);
        for (int i = 0; i < 4; i++) abit(1, 0);
        rdchk(8'hBB, aFl);
        intchk();
        for (int i = 0; i < 8; i++) abit($urandom & 1, 0);
        abit(0, 0);
        wr(8'hBC, 1);
        abit(1, 1);
        abit(0, 1);
        rdchk(8'hBB, aFl);
        wr(8'hBB, 2);
        rdchk(8'hBB, aFl);
        wr(8'hBC, 0);
        carrier(1'b0, 1);
        wr(8'hBA, 7);
        intchk();
        window($urandom % 3, 0);
        rdchk(8'hBB, aFl);
        wr(8'hBC, 2);
        window(3 + $urandom % 5, 1);
        window(3 + $urandom % 5, 1);
        window($urandom % 3, 1);
        window($urandom % 3, 1);
        wr(8'hBC, 0);
        window(5, 0);
        rdchk(8'hBB, aFl);
        carrier(1'b1, 0);
        wr(8'hBB, 7);
        intchk();
        wr(8'hC2, 0);
        k = nLatch;
        wr(8'hC2, 2);
        repeat (5) @(posedge clock);
        chk(32'(nLatch - k), 32'h1);
        wr(8'hC2, 1);
        k = nLatch;
        repeat (160) @(posedge clock);
        chk(32'(nLatch - k), 32'h3);
        wr(8'hC2, 0);
        k = nLatch;
        repeat (200) @(posedge clock);
        chk(32'(nLatch - k), 32'h0);
        test_done();
    end

    initial begin
        repeat (30000) @(posedge clock);
        n_fail++;
        test_done();
    end
endmodule
